// ==== core/io_cmd_consts.vh ====
// constants for the i/o processor command and error-report block
// assumes 48-bit memory words and word addressing on the memory port
`ifndef IO_CMD_CONSTS_VH
`define IO_CMD_CONSTS_VH
// apb register byte offsets
`define A_CMD       8'h00
`define A_BLK       8'h04
`define A_RES       8'h08
`define A_QH        8'h0c
`define A_RQH       8'h10
`define A_EBLK      8'h14
`define A_STAT      8'h18
`define A_HRF       8'h1c
// command codes
`define OP_WAIT_ERR 8'h01
`define OP_RD_STAT  8'h09
`define OP_DISC     8'h0a
`define OP_DEACT    8'h0b
// control block word offsets
`define CB_SELF     20'h00000
`define CB_NEXT     20'h00001
`define CB_STATE    20'h00002
// state/result word fields
`define SR_EXC      1
`define SR_LINK_ERR 2
`define SR_PROC_ERR 3
`define SR_HW_ERR   4
`define SR_IDX_LO   20
`define SR_CODE_LO  26
// queue header control word suspended bit
`define QH_SUSP     8
// status and error parameter word fields
`define W_TYPE_LO   40
`define W_REV_LO    32
`define W_MID_LO    24
// error codes
`define EC_DISC     8'h40
`define EC_IMPROPER 6'h0d
// descriptor tag placed on self pointers
`define SELF_TAG    4'h5
// error result area layout
`define EB_LAST_CTX 4'h9
`define EB_LAST_W   4'hb
`endif

// ==== core/io_cmd_error_report.v ====
// command interpreter and error reporter of an i/o message processor
// assumes an apb master for software and a word-addressed memory port
//
// Summary of operation
// - read status writes word at result pointer
// - status word holds type and firmware revision
// - status word holds host return field
// - status word holds ports-present bit vector
// - discontinue completes active error block, code 40
// - discontinue result bit0: 0 done, 1 none
// - deactivate sets suspended bit, then result queue
// - state bit2 link error, bit3 processor error
// - bit4 hardware fault, details to error block
// - unattached errors go to error block
// - one error block reference, active limit one
// - no error block: call maintenance, halt
// - error block completes without error bits
// - parameter word first, then nine context words
// - queue and memory faults reported via error block
// - null result pointer reported in own state word
// - enqueue error gives start block and word address
// - independent words first, dependent words after
// - result queue insert swaps head and self pointer
`timescale 1ns/1ps
`include "io_cmd_consts.vh"
module io_cmd_error_report #(
  parameter AW       = 20,
  parameter DW       = 48,
  parameter PORTS    = 8,
  parameter SYS_TYPE = 8'h3c, // arbitrary value
  parameter FW_REV   = 8'h01
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  output wire             mem_req,
  output wire             mem_we,
  output wire [AW-1:0]    mem_addr,
  output wire [DW-1:0]    mem_wdata,
  input  wire [DW-1:0]    mem_rdata,
  input  wire             mem_ack,
  input  wire [PORTS-1:0] ports_present,
  input  wire             err_req,
  input  wire [7:0]       err_code,
  input  wire [15:0]      err_link,
  input  wire             err_hw,
  input  wire [AW-1:0]    err_blk,
  input  wire [AW-1:0]    err_start,
  input  wire [AW-1:0]    err_word,
  output reg  [3:0]       ctx_sel,
  input  wire [DW-1:0]    ctx_data,
  output reg              maint_req,
  input  wire             maint_ack,
  output reg              halted
);
  localparam S_IDLE  = 4'd0;
  localparam S_STAT  = 4'd1;
  localparam S_DCHK  = 4'd2;
  localparam S_EPAR  = 4'd3;
  localparam S_ECTX  = 4'd4;
  localparam S_EST   = 4'd5;
  localparam S_EINS  = 4'd6;
  localparam S_DRES  = 4'd7;
  localparam S_QRD   = 4'd8;
  localparam S_QWR   = 4'd9;
  localparam S_FIN   = 4'd10;
  localparam S_INS   = 4'd11;
  localparam S_HWM   = 4'd12;
  localparam S_MAINT = 4'd13;
  localparam S_HALT  = 4'd14;

  reg [3:0]    state;
  reg [7:0]    cmd_op;
  reg          cmd_pend;
  reg          refused;
  reg [AW-1:0] blk_ptr;
  reg [AW-1:0] res_ptr;
  reg [AW-1:0] qh_ptr;
  reg [AW-1:0] rqh_ptr;
  reg [7:0]    host_ret;
  // single error block reference
  reg          eb_valid;
  reg          eb_attn;
  reg [AW-1:0] eb_blk;
  reg [AW-1:0] eb_res;
  reg [AW-1:0] eb_rqh;
  // pending error event
  reg          ep_valid;
  reg [7:0]    ep_code;
  reg [15:0]   ep_link;
  reg          ep_hw;
  reg [AW-1:0] ep_blk;
  reg [AW-1:0] ep_start;
  reg [AW-1:0] ep_word;
  reg          disc_hit;
  reg [DW-1:0] fin_word;
  reg [DW-1:0] qh_word;
  // own memory request
  reg          m_req;
  reg          m_we;
  reg [AW-1:0] m_addr;
  reg [DW-1:0] m_wdata;
  // insertion engine
  reg          ins_start;
  reg [AW-1:0] ins_blk;
  reg [AW-1:0] ins_head;
  wire          i_req;
  wire          i_we;
  wire [AW-1:0] i_addr;
  wire [DW-1:0] i_wdata;
  wire          i_done;
  wire          ins_act = (state == S_EINS) || (state == S_INS);
  wire          busy = (state != S_IDLE) || cmd_pend;
  wire          err_clr;

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire hit = (paddr == `A_CMD) || (paddr == `A_BLK) || (paddr == `A_RES) || (paddr == `A_QH) ||
             (paddr == `A_RQH) || (paddr == `A_EBLK) || (paddr == `A_STAT) || (paddr == `A_HRF);
  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // status word fields in fixed positions
  wire [DW-1:0] status_word = ({{(DW-8){1'b0}}, SYS_TYPE} << `W_TYPE_LO) |
                              ({{(DW-8){1'b0}}, FW_REV} << `W_REV_LO) |
                              ({{(DW-8){1'b0}}, host_ret} << `W_MID_LO) |
                              {{(DW-PORTS){1'b0}}, ports_present};
  // parameter word: type, revision, error code, link processor address
  wire [DW-1:0] param_word = ({{(DW-8){1'b0}}, SYS_TYPE} << `W_TYPE_LO) |
                             ({{(DW-8){1'b0}}, FW_REV} << `W_REV_LO) |
                             ({{(DW-8){1'b0}}, ep_code} << `W_MID_LO) |
                             {{(DW-16){1'b0}}, ep_link};
  wire [DW-1:0] one_w = {{(DW-1){1'b0}}, 1'b1};

  // port shared between own accesses and the insertion engine
  assign mem_req   = ins_act ? i_req : m_req;
  assign mem_we    = ins_act ? i_we : m_we;
  assign mem_addr  = ins_act ? i_addr : m_addr;
  assign mem_wdata = ins_act ? i_wdata : m_wdata;

  result_queue_insert #(.AW(AW), .DW(DW)) u_ins (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (ins_start),
    .blk       (ins_blk),
    .head      (ins_head),
    .mem_req   (i_req),
    .mem_we    (i_we),
    .mem_addr  (i_addr),
    .mem_wdata (i_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack),
    .done      (i_done)
  );

  // register read mux
  always @* begin
    prdata = 32'h00000000;
    if (rd) begin
      case (paddr)
        `A_CMD:  prdata = {24'h000000, cmd_op};
        `A_BLK:  prdata = {{(32-AW){1'b0}}, blk_ptr};
        `A_RES:  prdata = {{(32-AW){1'b0}}, res_ptr};
        `A_QH:   prdata = {{(32-AW){1'b0}}, qh_ptr};
        `A_RQH:  prdata = {{(32-AW){1'b0}}, rqh_ptr};
        `A_EBLK: prdata = {{(32-AW){1'b0}}, eb_blk};
        `A_STAT: prdata = {24'h000000, state == S_HALT, maint_req, eb_attn, eb_valid,
                           ep_valid, refused, busy, state == S_IDLE};
        `A_HRF:  prdata = {24'h000000, host_ret};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // pending error is consumed when its parameter word is written
  assign err_clr = (state == S_EPAR) && m_req && mem_ack && !disc_hit;

  // error capture; a new event in the clear cycle is kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_valid <= 1'b0;
      ep_code  <= 8'h00;
      ep_link  <= 16'h0000;
      ep_hw    <= 1'b0;
      ep_blk   <= {AW{1'b0}};
      ep_start <= {AW{1'b0}};
      ep_word  <= {AW{1'b0}};
    end else if (err_req && (!ep_valid || err_clr)) begin
      ep_valid <= 1'b1;
      ep_code  <= err_code;
      ep_link  <= err_link;
      ep_hw    <= err_hw;
      ep_blk   <= err_blk;
      ep_start <= err_start;
      ep_word  <= err_word;
    end else if (err_clr) begin
      ep_valid <= 1'b0;
    end
  end

  // software registers; pointers are frozen while a command runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_op   <= 8'h00;
      cmd_pend <= 1'b0;
      refused  <= 1'b0;
      blk_ptr  <= {AW{1'b0}};
      res_ptr  <= {AW{1'b0}};
      qh_ptr   <= {AW{1'b0}};
      rqh_ptr  <= {AW{1'b0}};
      host_ret <= 8'h00;
    end else begin
      if (state == S_IDLE && cmd_pend && !ep_valid) // error service first keeps the command
        cmd_pend <= 1'b0;
      if (wr && !busy) begin
        case (paddr)
          `A_CMD: begin
            cmd_op <= pwdata[7:0];
            // a second error block is refused while one is held
            refused <= (pwdata[7:0] == `OP_WAIT_ERR) ? eb_valid :
                       !((pwdata[7:0] == `OP_RD_STAT) || (pwdata[7:0] == `OP_DISC) ||
                         (pwdata[7:0] == `OP_DEACT));
            cmd_pend <= (pwdata[7:0] == `OP_RD_STAT) || (pwdata[7:0] == `OP_DISC) ||
                        (pwdata[7:0] == `OP_DEACT);
          end
          `A_BLK: blk_ptr  <= pwdata[AW-1:0];
          `A_RES: res_ptr  <= pwdata[AW-1:0];
          `A_QH:  qh_ptr   <= pwdata[AW-1:0];
          `A_RQH: rqh_ptr  <= pwdata[AW-1:0];
          `A_HRF: host_ret <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // main sequencer; every access is held until acknowledged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_IDLE;
      m_req     <= 1'b0;
      m_we      <= 1'b0;
      m_addr    <= {AW{1'b0}};
      m_wdata   <= {DW{1'b0}};
      eb_valid  <= 1'b0;
      eb_attn   <= 1'b0;
      eb_blk    <= {AW{1'b0}};
      eb_res    <= {AW{1'b0}};
      eb_rqh    <= {AW{1'b0}};
      disc_hit  <= 1'b0;
      fin_word  <= {DW{1'b0}};
      qh_word   <= {DW{1'b0}};
      ins_start <= 1'b0;
      ins_blk   <= {AW{1'b0}};
      ins_head  <= {AW{1'b0}};
      ctx_sel   <= 4'h0;
      maint_req <= 1'b0;
      halted    <= 1'b0;
    end else begin
      ins_start <= 1'b0;
      // single reference register taken from the wait-for-error command
      if (wr && !busy && paddr == `A_CMD && pwdata[7:0] == `OP_WAIT_ERR && !eb_valid) begin
        eb_valid <= 1'b1;
        eb_attn  <= pwdata[8];
        eb_blk   <= blk_ptr;
        eb_res   <= res_ptr;
        eb_rqh   <= rqh_ptr;
      end
      case (state)
        S_IDLE: begin
          fin_word <= {DW{1'b0}};
          disc_hit <= 1'b0;
          // errors are served before a new command
          if (ep_valid) begin
            if (ep_hw) begin
              state   <= S_HWM;
              m_req   <= 1'b1;
              m_we    <= 1'b1;
              m_addr  <= ep_blk + `CB_STATE;
              m_wdata <= one_w << `SR_HW_ERR;
            end else if (eb_valid) begin
              state <= S_EPAR;
            end else begin
              state     <= S_MAINT;
              maint_req <= 1'b1;
            end
          end else if (cmd_pend) begin
            case (cmd_op)
              `OP_RD_STAT: state <= S_STAT;
              `OP_DISC:    state <= S_DCHK;
              default:     state <= S_QRD;
            endcase
          end
        end
        S_HWM: begin
          if (mem_ack) begin
            m_req <= 1'b0;
            if (eb_valid) begin
              state <= S_EPAR;
            end else begin
              state     <= S_MAINT;
              maint_req <= 1'b1;
            end
          end
        end
        S_STAT: begin
          if (res_ptr == {AW{1'b0}}) begin
            // null result pointer is the block's own fault
            fin_word <= (one_w << `SR_PROC_ERR) | ({{(DW-6){1'b0}}, `EC_IMPROPER} << `SR_CODE_LO) |
                        (one_w << `SR_IDX_LO);
            state <= S_FIN;
          end else if (!m_req) begin
            m_req   <= 1'b1;
            m_we    <= 1'b1;
            m_addr  <= res_ptr;
            m_wdata <= status_word;
          end else if (mem_ack) begin
            m_req <= 1'b0;
            state <= S_FIN;
          end
        end
        S_DCHK: begin
          disc_hit <= eb_valid;
          state    <= eb_valid ? S_EPAR : S_DRES;
        end
        S_EPAR: begin
          if (!m_req) begin
            m_req  <= 1'b1;
            m_we   <= 1'b1;
            m_addr <= eb_res;
            m_wdata <= disc_hit ? ((param_word & ~({{(DW-8){1'b0}}, 8'hff} << `W_MID_LO)) |
                                   ({{(DW-8){1'b0}}, `EC_DISC} << `W_MID_LO)) : param_word;
          end else if (mem_ack) begin
            m_req   <= 1'b0;
            ctx_sel <= 4'h1;
            state   <= S_ECTX;
          end
        end
        S_ECTX: begin
          // words 1-9 are context registers, 10-11 the fault addresses
          if (!m_req) begin
            m_req  <= 1'b1;
            m_we   <= 1'b1;
            m_addr <= eb_res + {{(AW-4){1'b0}}, ctx_sel};
            if (ctx_sel <= `EB_LAST_CTX)
              m_wdata <= ctx_data;
            else if (ctx_sel == `EB_LAST_CTX + 4'h1)
              m_wdata <= {{(DW-AW){1'b0}}, ep_start};
            else
              m_wdata <= {{(DW-AW){1'b0}}, ep_word};
          end else if (mem_ack) begin
            m_req <= 1'b0;
            if (ctx_sel == `EB_LAST_W) begin
              ctx_sel <= 4'h0;
              state   <= S_EST;
            end else begin
              ctx_sel <= ctx_sel + 4'h1;
            end
          end
        end
        S_EST: begin
          if (!m_req) begin
            m_req   <= 1'b1;
            m_we    <= 1'b1;
            m_addr  <= eb_blk + `CB_STATE;
            m_wdata <= eb_attn ? (one_w << `SR_EXC) : {DW{1'b0}};
          end else if (mem_ack) begin
            m_req     <= 1'b0;
            ins_start <= 1'b1;
            ins_blk   <= eb_blk;
            ins_head  <= eb_rqh;
            state     <= S_EINS;
          end
        end
        S_EINS: begin
          if (i_done) begin
            eb_valid <= 1'b0;
            state    <= disc_hit ? S_DRES : S_IDLE;
          end
        end
        S_DRES: begin
          if (!m_req) begin
            m_req   <= 1'b1;
            m_we    <= 1'b1;
            m_addr  <= res_ptr;
            m_wdata <= disc_hit ? {DW{1'b0}} : one_w;
          end else if (mem_ack) begin
            m_req <= 1'b0;
            state <= S_FIN;
          end
        end
        S_QRD: begin
          if (!m_req) begin
            m_req  <= 1'b1;
            m_we   <= 1'b0;
            m_addr <= qh_ptr;
          end else if (mem_ack) begin
            qh_word <= mem_rdata | (one_w << `QH_SUSP);
            m_req   <= 1'b0;
            state   <= S_QWR;
          end
        end
        S_QWR: begin
          if (!m_req) begin
            m_req   <= 1'b1;
            m_we    <= 1'b1;
            m_wdata <= qh_word;
          end else if (mem_ack) begin
            m_req <= 1'b0;
            state <= S_FIN;
          end
        end
        S_FIN: begin
          // own state word, then the block joins its result queue
          if (!m_req) begin
            m_req   <= 1'b1;
            m_we    <= 1'b1;
            m_addr  <= blk_ptr + `CB_STATE;
            m_wdata <= fin_word;
          end else if (mem_ack) begin
            m_req     <= 1'b0;
            ins_start <= 1'b1;
            ins_blk   <= blk_ptr;
            ins_head  <= rqh_ptr;
            state     <= S_INS;
          end
        end
        S_INS: begin
          if (i_done)
            state <= S_IDLE;
        end
        S_MAINT: begin
          if (maint_ack) begin
            maint_req <= 1'b0;
            halted    <= 1'b1;
            state     <= S_HALT;
          end
        end
        S_HALT: state <= S_HALT; // left only by reset
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== core/result_queue_insert.v ====
// result queue insertion: swap head with self pointer, old head to next link
// assumes a word-addressed memory port held until mem_ack
`timescale 1ns/1ps
`include "io_cmd_consts.vh"
module result_queue_insert #(
  parameter AW = 20,
  parameter DW = 48
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          start,
  input  wire [AW-1:0] blk,
  input  wire [AW-1:0] head,
  output reg           mem_req,
  output reg           mem_we,
  output reg  [AW-1:0] mem_addr,
  output reg  [DW-1:0] mem_wdata,
  input  wire [DW-1:0] mem_rdata,
  input  wire          mem_ack,
  output reg           done
);
  localparam S_IDLE = 2'd0;
  localparam S_RD   = 2'd1;
  localparam S_HEAD = 2'd2;
  localparam S_NEXT = 2'd3;
  reg [1:0]    state;
  reg [DW-1:0] old_head;
  wire [DW-1:0] self_ptr = {`SELF_TAG, {(DW-4-AW){1'b0}}, blk};

  // three accesses per insertion, each held until acknowledged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= S_IDLE;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= {AW{1'b0}};
      mem_wdata <= {DW{1'b0}};
      old_head  <= {DW{1'b0}};
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            state    <= S_RD;
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= head;
          end
        end
        S_RD: begin
          if (mem_ack) begin
            old_head  <= mem_rdata;
            state     <= S_HEAD;
            mem_we    <= 1'b1;
            mem_wdata <= self_ptr;
          end
        end
        S_HEAD: begin
          if (mem_ack) begin
            state     <= S_NEXT;
            mem_addr  <= blk + `CB_NEXT;
            mem_wdata <= old_head;
          end
        end
        S_NEXT: begin
          if (mem_ack) begin
            state   <= S_IDLE;
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            done    <= 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== verif/io_cmd_chk.sv ====
// port-level properties of the command and error-report block
// assumes one clock domain with async active-low reset
`timescale 1ns/1ps
module io_cmd_chk #(
  parameter AW = 20,
  parameter DW = 48
) (
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire          mem_req,
  input wire          mem_we,
  input wire [AW-1:0] mem_addr,
  input wire [DW-1:0] mem_wdata,
  input wire          mem_ack,
  input wire          maint_req,
  input wire          maint_ack,
  input wire          halted
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem request moved");
  property p_wdata_hold;
    mem_req && mem_we && !mem_ack |=> $stable(mem_wdata);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved");
  property p_maint_hold;
    maint_req && !maint_ack |=> maint_req;
  endproperty
  a_maint_hold: assert property (p_maint_hold) else $error("maint request dropped");
  property p_halt_sticky;
    halted |=> halted;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt released");
  property p_halt_cause;
    $rose(halted) |-> $past(maint_ack);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without maint");
  property p_halt_quiet;
    halted |-> !mem_req && !maint_req;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("activity while halted");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_slverr;
    pslverr |-> psel && penable;
  endproperty
  a_slverr: assert property (p_slverr) else $error("slverr outside access");
  property p_rdata_idle;
    !(psel && penable && !pwrite) |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
endmodule
bind io_cmd_error_report io_cmd_chk #(.AW(AW), .DW(DW)) i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .maint_req, .maint_ack, .halted);

// ==== verif/mem_model.sv ====
// memory partner on the word-addressed port of the command block
// assumes word addresses fit the low 8 bits used here
`timescale 1ns/1ps
module mem_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         mem_req,
  input  wire         mem_we,
  input  wire  [19:0] mem_addr,
  input  wire  [47:0] mem_wdata,
  output logic [47:0] mem_rdata,
  output logic        mem_ack,
  input  wire  [3:0]  dly
);
  logic [47:0] m [0:255];
  logic [3:0]  cnt;
  // ack after dly waiting cycles; data lines toggle outside the ack cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 48'h0;
    end else if (mem_req && !mem_ack && cnt >= dly) begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      mem_rdata <= m[mem_addr[7:0]];
      if (mem_we)
        m[mem_addr[7:0]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata; // no stale value after release
    end
  end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for io_cmd_error_report with a memory partner
// assumes consts header on the include path
`timescale 1ns/1ps
`include "io_cmd_consts.vh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, err_req, err_hw, maint_ack;
  logic [7:0]  paddr, ports_present, err_code;
  logic [31:0] pwdata, rdat;
  logic [15:0] err_link;
  logic [19:0] err_blk, err_start, err_word;
  logic [3:0]  dly;
  logic        rerr;
  wire  [31:0] prdata;
  wire         pready, pslverr, mem_req, mem_we, mem_ack, maint_req, halted;
  wire  [19:0] mem_addr;
  wire  [47:0] mem_wdata, mem_rdata, ctx_data;
  wire  [3:0]  ctx_sel;
  int          n_fail, n_tests, cyc, k;
  // distinct context word per select value
  assign ctx_data = {12{ctx_sel}};
  io_cmd_error_report #(.SYS_TYPE(8'h5a), .FW_REV(8'h07)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .ports_present, .err_req, .err_code, .err_link, .err_hw, .err_blk,
    .err_start, .err_word, .ctx_sel, .ctx_data, .maint_req, .maint_ack, .halted);
  mem_model i_mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .dly);
  always #50 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  function automatic logic [47:0] mw(input logic [7:0] a);
    mw = i_mem.m[a];
  endfunction
  task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", s, e, g);
      n_fail++;
    end
  endtask
  // one apb transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, `A_STAT, 32'h0);
      if ((rdat[7:0] & m) === v) break;
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic att);
    apb(1'b1, `A_CMD, {23'h0, att, op});
    wait_stat(8'h1b & ~{3'h0, op == `OP_WAIT_ERR, 4'h0}, 8'h01);
  endtask
  task automatic ptrs(input logic [7:0] b, input logic [7:0] r, input logic [7:0] q);
    apb(1'b1, `A_BLK, {24'h0, b});
    apb(1'b1, `A_RES, {24'h0, r});
    apb(1'b1, `A_RQH, {24'h0, q});
  endtask
  task automatic pulse(input logic hw);
    err_hw <= hw;
    err_req <= 1'b1;
    @(posedge pclk);
    err_req <= 1'b0;
    @(posedge pclk);
  endtask
  task t_status;
    i_mem.m[8'h30] = 48'h123;
    i_mem.m[8'h12] = 48'hff;
    apb(1'b1, `A_HRF, 32'h96);
    ptrs(8'h10, 8'h20, 8'h30);
    cmd(`OP_RD_STAT, 1'b0);
    chk("status", {8'h5a, 8'h07, 8'h96, 16'h0, 8'ha5}, mw(8'h20));
    chk("state", 48'h0, mw(8'h12));
    chk("head", {4'h5, 24'h0, 20'h10}, mw(8'h30));
    chk("next", 48'h123, mw(8'h11));
    // null result pointer is reported in the block's own state word
    i_mem.m[8'h12] = 48'hff;
    apb(1'b1, `A_RES, 32'h0);
    cmd(`OP_RD_STAT, 1'b0);
    chk("null res", 48'h34100008, mw(8'h12));
    apb(1'b1, `A_RES, 32'h20);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 48'h1, {47'h0, rerr});
  endtask
  task t_disc_none;
    cmd(`OP_DISC, 1'b0);
    chk("no block", 48'h1, mw(8'h20));
  endtask
  task t_reg(input logic att);
    ptrs(8'h40, 8'h50, 8'h70);
    cmd(`OP_WAIT_ERR, att);
    apb(1'b1, `A_EBLK, 32'h0);
    apb(1'b0, `A_EBLK, 32'h0);
    chk("eblk", 48'h40, {16'h0, rdat});
  endtask
  task t_disc;
    apb(1'b1, `A_CMD, {24'h0, `OP_WAIT_ERR});
    apb(1'b0, `A_STAT, 32'h0);
    chk("refused", 48'h1, {47'h0, rdat[2]});
    i_mem.m[8'h42] = 48'hff;
    ptrs(8'h10, 8'h20, 8'h30);
    cmd(`OP_DISC, 1'b0);
    chk("disc param", {8'h5a, 8'h07, 8'h40}, mw(8'h50) >> 24);
    for (k = 1; k < 10; k++)
      chk("ctx", {12{k[3:0]}}, mw(8'h50 + k[7:0]));
    chk("eb state", 48'h0, mw(8'h42));
    chk("eb head", {4'h5, 24'h0, 20'h40}, mw(8'h70));
    chk("disc res", 48'h0, mw(8'h20));
  endtask
  task t_deact;
    dly <= 4'h3;
    i_mem.m[8'h38] = 48'h3;
    i_mem.m[8'h30] = 48'h0;
    apb(1'b1, `A_QH, 32'h38);
    cmd(`OP_DEACT, 1'b0);
    chk("suspend", 48'h103, mw(8'h38));
    chk("deact head", {4'h5, 24'h0, 20'h10}, mw(8'h30));
  endtask
  task t_err;
    i_mem.m[8'h8a] = 48'hff;
    pulse(1'b1);
    wait_stat(8'h19, 8'h01);
    chk("hw mark", 48'h10, mw(8'h8a));
    chk("param", {8'h5a, 8'h07, 8'h20, 8'h00, 16'h0123}, mw(8'h50));
    chk("start", 48'he1, mw(8'h5a) & 48'hfffff);
    chk("word", 48'he7, mw(8'h5b) & 48'hfffff);
    chk("att state", 48'h2, mw(8'h42));
  endtask
  task t_halt;
    pulse(1'b0);
    for (k = 0; k < 60 && maint_req !== 1'b1; k++) @(posedge pclk);
    chk("maint", 48'h2, {46'h0, maint_req, halted});
    maint_ack <= 1'b1;
    for (k = 0; k < 60 && halted !== 1'b1; k++) @(posedge pclk);
    apb(1'b0, `A_STAT, 32'h0);
    chk("halted", 48'h1, {47'h0, rdat[7]});
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, err_req, err_hw, maint_ack} = 8'h0;
    {paddr, pwdata, dly} = 44'h0;
    ports_present = 8'ha5;
    err_code = 8'h20;
    err_link = 16'h0123;
    err_blk = 20'h88;
    err_start = 20'he1;
    err_word = 20'he7;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_status;
    t_disc_none;
    t_reg(1'b0);
    t_disc;
    t_deact;
    t_reg(1'b1);
    t_err;
    t_halt;
    stop_test;
  end
endmodule
